//--- cpel_regs.svh
// register offsets, field positions and reset values of the channel power-down block
`ifndef CPEL_REGS_SVH
`define CPEL_REGS_SVH

// ==========================================================================
// register offsets
`define CPEL_ADDR_W 10
`define CPEL_OFS_CHANNEL_POWER_DOWN 10'h209
`define CPEL_OFS_EXTRA_LANE_A 10'h20a
`define CPEL_OFS_EXTRA_LANE_B 10'h20b

// ==========================================================================
// field positions
`define CPEL_ADC_A_PD_BIT 0
`define CPEL_ADC_B_PD_BIT 1
`define CPEL_ADDITIONAL_SER_BIT 0
`define CPEL_LANES 8

// ==========================================================================
// reset values
`define CPEL_RST_CHANNEL_POWER_DOWN 8'h00
`define CPEL_RST_EXTRA_LANE 8'h00
`define CPEL_READ_ZERO 8'h00

`endif

//--- cpel_pkg.sv
// types shared by both ends of the channel power-down and extra-lane block
package cpel_pkg;

  // ==========================================================================
  // types
  typedef logic [9:0] cpel_addr_t;
  typedef logic [7:0] cpel_byte_t;
  typedef enum logic [1:0] {CPEL_IDLE, CPEL_ISSUE, CPEL_WAIT} cpel_host_state_t;

endpackage

//--- cpel_if.sv
// interface joining the register master with the power-down and lane control
`timescale 1ns/10ps
interface cpel_if;
  logic wr;
  logic rd;
  cpel_pkg::cpel_addr_t addr;
  cpel_pkg::cpel_byte_t wdata;
  cpel_pkg::cpel_byte_t rdata;
  logic rvalid;
  logic serial_link_enable;
  logic global_power_down;
  logic [4:0] link_mode_select;
  logic [3:0] test_pattern_select;

  modport dev (
    input wr, rd, addr, wdata, serial_link_enable, global_power_down,
    input link_mode_select, test_pattern_select,
    output rdata, rvalid
  );
  modport host (
    output wr, rd, addr, wdata, serial_link_enable, global_power_down,
    output link_mode_select, test_pattern_select,
    input rdata, rvalid
  );
endinterface

//--- cpel_device.sv
// device end: power-down register, extra-lane registers and lane clock control
`timescale 1ns/10ps
`include "cpel_regs.svh"

// Summary of operation
// RULE_01 - bit0 powers ADC A, bit1 ADC B
// RULE_02 - bound digital channels follow their ADC
// RULE_03 - clear link enable before power-down write
// RULE_04 - both channels off goes via global mode
// RULE_05 - both off kills whole serial subsystem
// RULE_06 - link A lives on, B slots undefined
// RULE_07 - link A bits 7..1 enable lanes A1..A7
// RULE_08 - link B bits 7..1 enable lanes B1..B7
// RULE_09 - extra bit alone gives only lane clocks
// RULE_10 - bit0 also turns extra serializers on
// RULE_11 - extra-lane writes only with link disabled
// RULE_12 - extra lanes share link mode and pattern
// RULE_13 - powered-down link keeps extra lanes inactive
// RULE_14 - serializer n needs lanes 0..n-1 enabled
// RULE_15 - reserved bits stored, no effect, reset zero
module cpel_device #(
  parameter int LANES = `CPEL_LANES
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // register side
  cpel_if.dev BUS,
  // binding and mode decode from the converter core
  input wire logic DIG_A_ON_ADC_B,
  input wire logic DIG_B_ON_ADC_B,
  input wire logic AB_ON_LINK_A,
  input wire logic [LANES-1:0] BASE_LANES_A,
  input wire logic [LANES-1:0] BASE_LANES_B,
  // power-down outputs
  output logic ADC_A_PD,
  output logic ADC_B_PD,
  output logic DIG_A_PD,
  output logic DIG_B_PD,
  output logic SERDES_SUBSYS_PD,
  output logic B_SLOTS_UNDEFINED,
  // lane outputs
  output logic [LANES-1:0] LANE_CLK_EN_A,
  output logic [LANES-1:0] LANE_CLK_EN_B,
  output logic [LANES-1:0] SER_EN_A,
  output logic [LANES-1:0] SER_EN_B,
  output logic [4:0] LANE_MODE,
  output logic [3:0] LANE_TEST
);

  // ==========================================================================
  // helpers
  // a serializer is enabled only if its own and every lower lane clock is running
  function automatic logic [LANES-1:0] chain_ok(input logic [LANES-1:0] clk_en);
    logic [LANES-1:0] ok;
    ok = '0;
    ok[0] = clk_en[0];
    for (int i = 1; i < LANES; i++) begin
      ok[i] = ok[i-1] & clk_en[i];
    end
    return ok;
  endfunction

  // ==========================================================================
  // register file
  cpel_pkg::cpel_byte_t pd_reg, pd_next;
  cpel_pkg::cpel_byte_t xa_reg, xa_next;
  cpel_pkg::cpel_byte_t xb_reg, xb_next;
  cpel_pkg::cpel_byte_t rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  // writes are taken as given; the master keeps the link disabled meanwhile
  always_comb begin
    pd_next = pd_reg;
    xa_next = xa_reg;
    xb_next = xb_reg;
    rdata_next = rdata_reg;
    rvalid_next = BUS.rd;
    if (BUS.wr) begin
      unique case (BUS.addr)
        `CPEL_OFS_CHANNEL_POWER_DOWN: pd_next = BUS.wdata; // see RULE_15
        `CPEL_OFS_EXTRA_LANE_A: xa_next = BUS.wdata;
        `CPEL_OFS_EXTRA_LANE_B: xb_next = BUS.wdata;
        default: pd_next = pd_reg; // unmapped write is dropped
      endcase
    end
    if (BUS.rd) begin
      unique case (BUS.addr)
        `CPEL_OFS_CHANNEL_POWER_DOWN: rdata_next = pd_reg;
        `CPEL_OFS_EXTRA_LANE_A: rdata_next = xa_reg;
        `CPEL_OFS_EXTRA_LANE_B: rdata_next = xb_reg;
        default: rdata_next = `CPEL_READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pd_reg <= `CPEL_RST_CHANNEL_POWER_DOWN;
      xa_reg <= `CPEL_RST_EXTRA_LANE;
      xb_reg <= `CPEL_RST_EXTRA_LANE;
      rdata_reg <= `CPEL_READ_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      pd_reg <= pd_next;
      xa_reg <= xa_next;
      xb_reg <= xb_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign BUS.rdata = rdata_reg;
  assign BUS.rvalid = rvalid_reg;

  // ==========================================================================
  // power and lane decode
  logic adc_a_pd, adc_b_pd, dig_a_pd, dig_b_pd, subsys_pd;
  logic link_a_down, link_b_down, slots_undef;
  logic [LANES-1:0] clk_a, clk_b, ser_a, ser_b;
  logic [LANES-1:0] want_a, want_b;

  always_comb begin
    // global mode power-down covers the both-channels case
    adc_a_pd = pd_reg[`CPEL_ADC_A_PD_BIT] | BUS.global_power_down; // see RULE_01
    adc_b_pd = pd_reg[`CPEL_ADC_B_PD_BIT] | BUS.global_power_down; // see RULE_01
    // each digital channel follows the ADC it is bound to
    dig_a_pd = DIG_A_ON_ADC_B ? adc_b_pd : adc_a_pd; // see RULE_02
    dig_b_pd = DIG_B_ON_ADC_B ? adc_b_pd : adc_a_pd; // see RULE_02
    subsys_pd = adc_a_pd & adc_b_pd; // see RULE_05
    // a shared link A needs only one live digital channel
    link_a_down = subsys_pd | (dig_a_pd & (!AB_ON_LINK_A | dig_b_pd)); // see RULE_06
    link_b_down = subsys_pd | dig_b_pd;
    slots_undef = AB_ON_LINK_A & dig_b_pd & !link_a_down; // see RULE_06
    // extra bits 7..1 map straight onto lanes 1..7, lane 0 is never extra
    want_a = BASE_LANES_A | {xa_reg[LANES-1:1], 1'b0}; // see RULE_07
    want_b = BASE_LANES_B | {xb_reg[LANES-1:1], 1'b0}; // see RULE_08
    // a powered-down link keeps every lane dark, extra or not
    clk_a = link_a_down ? '0 : want_a; // see RULE_13
    clk_b = link_b_down ? '0 : want_b; // see RULE_13
    // extra lanes get a serializer only when the extra-serializer bit is set
    ser_a = clk_a & (BASE_LANES_A | {LANES{xa_reg[`CPEL_ADDITIONAL_SER_BIT]}}); // see RULE_09
    ser_b = clk_b & (BASE_LANES_B | {LANES{xb_reg[`CPEL_ADDITIONAL_SER_BIT]}}); // see RULE_10
    ser_a = ser_a & chain_ok(clk_a) & {LANES{BUS.serial_link_enable}}; // see RULE_14
    ser_b = ser_b & chain_ok(clk_b) & {LANES{BUS.serial_link_enable}}; // see RULE_14
  end

  // outputs are registered so the analog side sees clean levels
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ADC_A_PD <= 1'b0;
      ADC_B_PD <= 1'b0;
      DIG_A_PD <= 1'b0;
      DIG_B_PD <= 1'b0;
      SERDES_SUBSYS_PD <= 1'b0;
      B_SLOTS_UNDEFINED <= 1'b0;
      LANE_CLK_EN_A <= '0;
      LANE_CLK_EN_B <= '0;
      SER_EN_A <= '0;
      SER_EN_B <= '0;
      LANE_MODE <= 5'h00;
      LANE_TEST <= 4'h0;
    end else begin
      ADC_A_PD <= adc_a_pd;
      ADC_B_PD <= adc_b_pd;
      DIG_A_PD <= dig_a_pd;
      DIG_B_PD <= dig_b_pd;
      SERDES_SUBSYS_PD <= subsys_pd;
      B_SLOTS_UNDEFINED <= slots_undef;
      LANE_CLK_EN_A <= clk_a;
      LANE_CLK_EN_B <= clk_b;
      SER_EN_A <= ser_a;
      SER_EN_B <= ser_b;
      LANE_MODE <= BUS.link_mode_select; // see RULE_12
      LANE_TEST <= BUS.test_pattern_select; // see RULE_12
    end
  end

endmodule

//--- cpel_host.sv
// host end: register master that keeps the link disabled around protected writes
`timescale 1ns/10ps
`include "cpel_regs.svh"

module cpel_host (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // register side
  cpel_if.host BUS,
  // command port
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic [9:0] CMD_ADDR,
  input wire logic [7:0] CMD_WDATA,
  output logic CMD_READY,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  // link settings wanted by software
  input wire logic LINK_EN_REQ,
  input wire logic [4:0] MODE_SEL,
  input wire logic [3:0] TEST_SEL
);

  // ==========================================================================
  // helpers
  // every lane from lane 1 up to the highest requested extra lane is filled in; bit 0 is left alone
  function automatic logic [7:0] fill_down(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    for (int i = 6; i >= 1; i--) begin
      r[i] = r[i] | r[i+1];
    end
    return r;
  endfunction

  function automatic logic in_block(input logic [9:0] a);
    return a == `CPEL_OFS_CHANNEL_POWER_DOWN || a == `CPEL_OFS_EXTRA_LANE_A ||
           a == `CPEL_OFS_EXTRA_LANE_B;
  endfunction

  // ==========================================================================
  // command sequencer
  cpel_pkg::cpel_host_state_t state_reg, state_next;
  logic wr_reg, wr_next;
  logic [9:0] addr_reg, addr_next;
  logic [7:0] data_reg, data_next;
  logic link_en_reg, link_en_next;
  logic gpd_reg, gpd_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [7:0] rsp_data_reg, rsp_data_next;
  logic [7:0] wval;

  // a protected write clears the link enable on the edge that accepts it, so the
  // device sees it low with the write strobe; cost is two idle cycles on the link
  always_comb begin
    state_next = state_reg;
    wr_next = wr_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    link_en_next = link_en_reg;
    gpd_next = gpd_reg;
    rsp_valid_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    wval = CMD_WDATA;
    if (CMD_WRITE && CMD_ADDR != `CPEL_OFS_CHANNEL_POWER_DOWN &&
        wval[`CPEL_ADDITIONAL_SER_BIT]) begin
      wval = fill_down(CMD_WDATA); // see RULE_14
    end
    if (CMD_WRITE && CMD_ADDR == `CPEL_OFS_CHANNEL_POWER_DOWN) begin
      if (wval[`CPEL_ADC_A_PD_BIT] && wval[`CPEL_ADC_B_PD_BIT]) begin
        wval[`CPEL_ADC_B_PD_BIT:`CPEL_ADC_A_PD_BIT] = 2'b00; // see RULE_04
      end
    end
    unique case (state_reg)
      cpel_pkg::CPEL_IDLE: begin
        link_en_next = LINK_EN_REQ;
        if (CMD_VALID) begin
          wr_next = CMD_WRITE;
          addr_next = CMD_ADDR;
          data_next = wval;
          state_next = cpel_pkg::CPEL_ISSUE;
          if (CMD_WRITE && in_block(CMD_ADDR)) begin
            link_en_next = 1'b0; // see RULE_03, see RULE_11
          end
          if (CMD_WRITE && CMD_ADDR == `CPEL_OFS_CHANNEL_POWER_DOWN) begin
            gpd_next = CMD_WDATA[`CPEL_ADC_A_PD_BIT] &
              CMD_WDATA[`CPEL_ADC_B_PD_BIT]; // see RULE_04
          end
        end
      end
      cpel_pkg::CPEL_ISSUE: begin
        state_next = wr_reg ? cpel_pkg::CPEL_IDLE : cpel_pkg::CPEL_WAIT;
      end
      cpel_pkg::CPEL_WAIT: begin
        if (BUS.rvalid) begin
          rsp_valid_next = 1'b1;
          rsp_data_next = BUS.rdata;
          state_next = cpel_pkg::CPEL_IDLE;
        end
      end
      // the fourth code of the state word is unused; fall back to idle
      default: state_next = cpel_pkg::CPEL_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_reg <= cpel_pkg::CPEL_IDLE;
      wr_reg <= 1'b0;
      addr_reg <= 10'h000;
      data_reg <= 8'h00;
      link_en_reg <= 1'b0;
      gpd_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      link_en_reg <= link_en_next;
      gpd_reg <= gpd_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
    end
  end

  // bus strobes last exactly the issue cycle
  assign BUS.wr = (state_reg == cpel_pkg::CPEL_ISSUE) & wr_reg;
  assign BUS.rd = (state_reg == cpel_pkg::CPEL_ISSUE) & !wr_reg;
  assign BUS.addr = addr_reg;
  assign BUS.wdata = data_reg;
  assign BUS.serial_link_enable = link_en_reg;
  assign BUS.global_power_down = gpd_reg;
  assign BUS.link_mode_select = MODE_SEL;
  assign BUS.test_pattern_select = TEST_SEL;
  assign CMD_READY = (state_reg == cpel_pkg::CPEL_IDLE);
  assign RSP_VALID = rsp_valid_reg;
  assign RSP_DATA = rsp_data_reg;

endmodule

//--- cpel_monitor.sv
// checker of the register bus between host and device ends
`timescale 1ns/10ps
module cpel_monitor (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // register bus
  input wire logic wr,
  input wire logic rd,
  input wire cpel_pkg::cpel_addr_t addr,
  input wire cpel_pkg::cpel_byte_t wdata,
  input wire logic rvalid,
  input wire logic serial_link_enable,
  input wire logic global_power_down
);
  // ==========================================================================
  // bus properties, all in the core clock domain
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  a_pd_link_off: assert property (wr && addr == 10'h209 |-> !serial_link_enable)
    else $error("power-down write with link on");
  a_lane_link_off: assert property (
    wr && addr[9:1] == 9'h105 |-> !serial_link_enable)
    else $error("extra-lane write with link on");
  a_quiet_after_wr: assert property (wr |=> !serial_link_enable)
    else $error("link back on one cycle after write");
  a_no_dual_pd: assert property (wr && addr == 10'h209 |-> wdata[1:0] != 2'b11)
    else $error("both channel bits written");
  a_global_link_off: assert property (
    $rose(global_power_down) |-> !serial_link_enable)
    else $error("global power-down with link on");
  // serializer writes must carry a gap-free lane set from lane 1 up
  a_fill_down: assert property (wr && addr[9:1] == 9'h105 && wdata[0] |->
    (wdata[7:1] & (wdata[7:1] + 7'h01)) == 7'h00) else $error("lane gap below serializer");
  a_read_answer: assert property (rd |=> rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (rvalid |-> $past(rd))
    else $error("answer without read");
  c_pd_write: cover property (wr && addr == 10'h209);
  c_ser_b: cover property (wr && addr == 10'h20b && wdata[0]);
  c_global: cover property ($rose(global_power_down));
endmodule

//--- channel_powerdown_extra_lane_ctrl_test.sv
// self-checking bench joining the host and device ends
`timescale 1ns/10ps
module channel_powerdown_extra_lane_ctrl_test;
  // ==========================================================================
  // stimulus, observed signals and instances
  logic core_clk, rst_n, cmd_valid, cmd_write, link_en_req, dig_a_b, dig_b_b, ab_on_a;
  logic cmd_ready, rsp_valid, adc_a_pd, adc_b_pd, dig_a_pd, dig_b_pd, sub_pd, b_undef;
  logic [9:0] cmd_addr;
  logic [7:0] cmd_wdata, base_a, base_b, rsp_data, clk_a, clk_b, ser_a, ser_b, got;
  logic [4:0] mode_sel, lane_mode;
  logic [3:0] test_sel, lane_test;
  int bad_count = 0;
  int compares = 0;
  cpel_if i_cpel_if();
  cpel_host i_cpel_host (.CORE_CLK(core_clk), .RST_N(rst_n), .BUS(i_cpel_if.host),
    .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
    .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
    .LINK_EN_REQ(link_en_req), .MODE_SEL(mode_sel), .TEST_SEL(test_sel));
  cpel_device i_cpel_device (.CORE_CLK(core_clk), .RST_N(rst_n), .BUS(i_cpel_if.dev),
    .DIG_A_ON_ADC_B(dig_a_b), .DIG_B_ON_ADC_B(dig_b_b), .AB_ON_LINK_A(ab_on_a),
    .BASE_LANES_A(base_a), .BASE_LANES_B(base_b), .ADC_A_PD(adc_a_pd), .ADC_B_PD(adc_b_pd),
    .DIG_A_PD(dig_a_pd), .DIG_B_PD(dig_b_pd), .SERDES_SUBSYS_PD(sub_pd),
    .B_SLOTS_UNDEFINED(b_undef), .LANE_CLK_EN_A(clk_a), .LANE_CLK_EN_B(clk_b),
    .SER_EN_A(ser_a), .SER_EN_B(ser_b), .LANE_MODE(lane_mode), .LANE_TEST(lane_test));
  cpel_monitor i_cpel_monitor (.CORE_CLK(core_clk), .RST_N(rst_n), .wr(i_cpel_if.wr),
    .rd(i_cpel_if.rd), .addr(i_cpel_if.addr), .wdata(i_cpel_if.wdata),
    .rvalid(i_cpel_if.rvalid), .serial_link_enable(i_cpel_if.serial_link_enable),
    .global_power_down(i_cpel_if.global_power_down));

  // ==========================================================================
  // shared tasks
  task automatic report_and_stop();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // bounded wait at falling edges; a hang ends the run
  // want_rsp picks the response strobe, otherwise the command ready
  task automatic wait_high(input bit want_rsp);
    int n;
    n = 0;
    while ((want_rsp ? rsp_valid : cmd_ready) !== 1'b1) begin
      @(negedge core_clk);
      n++;
      if (n > 50) begin
        chk("handshake", 8'h01, 8'h00);
        report_and_stop();
      end
    end
  endtask
  // one host command; a write waits until its effect reaches the outputs
  task automatic cmd(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    wait_high(1'b0);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    if (w) begin
      wait_high(1'b0);
      repeat (3) @(negedge core_clk);
    end else begin
      wait_high(1'b1);
      got = rsp_data;
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    cmd(1'b0, 10'h209, 8'h00);
    chk("pd reg", 8'h00, got);
    cmd(1'b0, 10'h20a, 8'h00);
    chk("lane a reg", 8'h00, got);
    cmd(1'b0, 10'h20b, 8'h00);
    chk("lane b reg", 8'h00, got);
    cmd(1'b0, 10'h20c, 8'h00);
    chk("unmapped", 8'h00, got);
  endtask
  // channel a down with reserved bits set, then rebinding digital b onto it
  task automatic t_pd_a();
    cmd(1'b1, 10'h209, 8'ha9);
    cmd(1'b0, 10'h209, 8'h00);
    chk("pd reg", 8'ha9, got);
    chk("adc pd", 8'h01, {6'h00, adc_b_pd, adc_a_pd});
    chk("dig pd", 8'h01, {6'h00, dig_b_pd, dig_a_pd});
    dig_b_b = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("dig b pd", 8'h01, {7'h00, dig_b_pd});
    dig_b_b = 1'b1;
  endtask
  // b down while link a carries both: link a stays, b slots undefined
  task automatic t_slots();
    ab_on_a = 1'b1;
    cmd(1'b1, 10'h209, 8'hfe);
    chk("adc a pd", 8'h00, {7'h00, adc_a_pd});
    chk("b slots", 8'h01, {7'h00, b_undef});
    chk("sub pd", 8'h00, {7'h00, sub_pd});
    cmd(1'b1, 10'h209, 8'h00);
  endtask
  task automatic t_lanes();
    cmd(1'b1, 10'h20a, 8'h08);
    chk("clk a", 8'h09, clk_a);
    chk("ser a3", 8'h00, {7'h00, ser_a[3]});
    cmd(1'b1, 10'h20a, 8'h11);
    cmd(1'b0, 10'h20a, 8'h00);
    chk("lane a reg", 8'h1f, got);
    chk("ser a", 8'h1f, ser_a);
    cmd(1'b1, 10'h20b, 8'h80);
    chk("clk b", 8'h81, clk_b);
    chk("ser b7", 8'h00, {7'h00, ser_b[7]});
    cmd(1'b1, 10'h20b, 8'h07);
    chk("ser b", 8'h07, ser_b);
    chk("mode", {3'h0, mode_sel}, {3'h0, lane_mode});
    chk("test", {4'h0, test_sel}, {4'h0, lane_test});
  endtask
  // both channels asked down: global path, whole subsystem and lanes off
  task automatic t_both();
    cmd(1'b1, 10'h209, 8'h03);
    chk("adc pd", 8'h03, {6'h00, adc_b_pd, adc_a_pd});
    chk("sub pd", 8'h01, {7'h00, sub_pd});
    chk("ser a", 8'h00, ser_a);
    chk("ser b", 8'h00, ser_b);
    cmd(1'b1, 10'h209, 8'h00);
    chk("sub pd", 8'h00, {7'h00, sub_pd});
  endtask

  // ==========================================================================
  // clock and main sequence
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 10'h000;
    cmd_wdata = 8'h00;
    link_en_req = 1'b1;
    mode_sel = 5'h0b;
    test_sel = 4'h3;
    dig_a_b = 1'b0;
    dig_b_b = 1'b1;
    ab_on_a = 1'b0;
    base_a = 8'h01;
    base_b = 8'h01;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset();
    t_pd_a();
    t_slots();
    t_lanes();
    t_both();
    report_and_stop();
  end
endmodule
